/* File: logic/swr_status_regs.sv */
`timescale 1ns/1ps
module swr_status_regs (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_rd_en,
	input wire logic [7:0] i_rd_addr,
	input wire logic i_err_clear,
	input wire logic i_warn_clear,
	input wire logic i_turns_reset,
	input wire logic i_hard_reset,
	input wire logic i_regulator_undervolt,
	input wire logic [11:0] i_field_sample,
	input wire logic [11:0] i_low_field_threshold,
	input wire logic [11:0] i_high_field_threshold,
	input wire logic i_temp_valid,
	input wire logic signed [13:0] i_temp_raw,
	input wire logic i_pkt_done,
	input wire logic [5:0] i_pkt_bit_count,
	input wire logic i_pkt_bit15,
	input wire logic i_manchester_err,
	input wire logic i_serial_crc_check_enable,
	input wire logic i_pkt_crc_ok,
	input wire logic i_slew_limit_enable,
	input wire logic i_slew_limit_needed,
	input wire logic i_ext_start,
	input wire logic i_ext_cmd_done,
	input wire logic i_ext_write,
	input wire logic i_unlocked,
	input wire logic i_eeprom_write_fail,
	input wire logic i_eeprom_loading,
	input wire logic i_ecc_corrected,
	input wire logic i_sat_any,
	input wire logic i_low_power_mode,
	input wire logic i_awake_strobe,
	input wire logic [11:0] i_zcd_angle,
	input wire logic i_turns_overflow,
	input wire logic [2:0] i_err_mask,
	input wire logic [11:0] i_warn_mask,
	output logic [15:0] o_rd_data,
	output logic o_rd_valid,
	output swr_pkg::swr_err_type o_err_low_flags,
	output logic o_summary_error_bit,
	output logic o_pkt_discard
);
	import swr_pkg::*;

	// =====================================================================
	// helpers
	function automatic logic [11:0] ang_dist(input logic [11:0] a, input logic [11:0] b);
		logic [11:0] d;
		d = a - b;
		ang_dist = d[11] ? 12'(12'h000 - d) : d;
	endfunction

	function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] base);
		word_hit = (addr[7:1] == base[7:1]);
	endfunction

	// =====================================================================
	// internal state
	logic uv_sync;
	logic [11:0] temp_word;
	logic temp_range_pulse;
	logic [10:0] field_cnt_q;
	logic field_tick;
	logic [11:0] field_q;
	logic ext_busy_q;
	logic [11:0] prev_angle_q;
	logic prev_angle_ok_q;
	swr_err_type err_q;
	logic [11:0] warn_q;
	logic [11:0] warn_set;
	logic frame_bad;
	logic crc_bad;
	swr_warn_type warn_word;

	// analog detector arrives from outside the clock domain
	swr_sync #(
		.WIDTH(1)
	) u_uv_sync (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_async(i_regulator_undervolt),
		.o_sync(uv_sync)
	);

	swr_temp_sat u_temp (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_valid(i_temp_valid),
		.i_raw(i_temp_raw),
		.o_temp(temp_word),
		.o_out_of_range(temp_range_pulse)
	);

	// =====================================================================
	// field refresh divider
	assign field_tick = (field_cnt_q == FIELD_CNT_LAST);

	// free-running period counter; one-cycle tick per period
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			field_cnt_q <= '0;
		end else if (field_tick) begin
			field_cnt_q <= '0;
		end else begin
			field_cnt_q <= field_cnt_q + 11'h001;
		end
	end

	// field word only moves on the tick so a read sees a stable sample
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			field_q <= FIELD_RESET_VAL;
		end else if (field_tick) begin
			field_q <= i_field_sample;
		end
	end

	// =====================================================================
	// extended access tracking and awake-angle memory
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			ext_busy_q <= 1'b0;
		end else if (i_ext_start) begin
			ext_busy_q <= 1'b1;
		end else if (i_ext_cmd_done) begin
			ext_busy_q <= 1'b0;
		end
	end

	// first awake sample after entering low power only seeds the reference
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			prev_angle_q <= 12'h000;
			prev_angle_ok_q <= 1'b0;
		end else if (!i_low_power_mode) begin
			prev_angle_ok_q <= 1'b0;
		end else if (i_awake_strobe) begin
			prev_angle_q <= i_zcd_angle;
			prev_angle_ok_q <= 1'b1;
		end
	end

	// =====================================================================
	// warning set terms
	assign frame_bad = i_pkt_done && ((i_pkt_bit_count != PKT_BITS) || i_pkt_bit15);
	assign crc_bad = i_pkt_done && !frame_bad && i_serial_crc_check_enable && !i_pkt_crc_ok;

	always_comb begin
		warn_set = 12'h000;
		warn_set[11] = frame_bad || i_manchester_err;
		warn_set[10] = crc_bad;
		warn_set[9] = 1'b0;
		warn_set[8] = i_slew_limit_enable && i_slew_limit_needed;
		warn_set[7] = i_ext_cmd_done && i_ext_write && (!i_unlocked || i_eeprom_write_fail);
		warn_set[6] = temp_range_pulse;
		warn_set[5] = i_eeprom_loading && i_ecc_corrected;
		warn_set[4] = i_sat_any;
		warn_set[3] = i_low_power_mode && i_awake_strobe && prev_angle_ok_q
			&& (ang_dist(i_zcd_angle, prev_angle_q) > TURNS_WARN_CODE);
		warn_set[2] = i_ext_start && ext_busy_q;
		warn_set[1] = field_tick && (i_field_sample > i_high_field_threshold);
		warn_set[0] = i_turns_overflow;
	end

	// =====================================================================
	// sticky warnings; a set in the clear cycle wins
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			warn_q <= WARN_RESET_VAL;
		end else begin
			warn_q[11:1] <= (i_warn_clear ? 11'h000 : warn_q[11:1]) | warn_set[11:1];
			warn_q[0] <= (i_turns_reset ? 1'b0 : warn_q[0]) | warn_set[0];
		end
	end

	// discarded packet notice to the serial front end
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_pkt_discard <= 1'b0;
		end else begin
			o_pkt_discard <= frame_bad || crc_bad;
		end
	end

	// =====================================================================
	// sticky error flags; undervolt keeps re-setting while the fault stays
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			err_q <= ERR_RESET_VAL;
		end else begin
			err_q.regulator_undervolt_flag <= (!i_err_clear && err_q.regulator_undervolt_flag)
				|| uv_sync;
			err_q.low_field_flag <= (!i_err_clear && err_q.low_field_flag)
				|| (field_tick && (i_field_sample < i_low_field_threshold));
			// self-test never reaches this input, only true resets do
			err_q.reset_flag <= (!i_err_clear && err_q.reset_flag) || i_hard_reset;
		end
	end

	// registered copy so the flag output leaves straight from a flip-flop
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_err_low_flags <= ERR_RESET_VAL;
		end else begin
			o_err_low_flags <= err_q;
		end
	end

	// summary bit; one cycle behind the flags it reports
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_summary_error_bit <= 1'b0;
		end else begin
			o_summary_error_bit <= (|(err_q & ~i_err_mask)) || (|(warn_q & ~i_warn_mask));
		end
	end

	// =====================================================================
	// read port: side-effect free, one cycle latency
	assign warn_word = swr_warn_type'({WARN_ID, warn_q[11:10], 1'b0, warn_q[8:0]});

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_rd_data <= 16'h0000;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_en;
			if (!i_rd_en) begin
				o_rd_data <= 16'h0000;
			end else if (word_hit(i_rd_addr, WARN_ADDR)) begin
				o_rd_data <= warn_word;
			end else if (word_hit(i_rd_addr, TEMP_ADDR)) begin
				o_rd_data <= {TEMP_ID, temp_word};
			end else if (word_hit(i_rd_addr, FIELD_ADDR)) begin
				o_rd_data <= {FIELD_ID, field_q};
			end else begin
				o_rd_data <= 16'h0000;
			end
		end
	end

	// =====================================================================
	// checks
	chk_uv_latch: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		uv_sync |=> err_q.regulator_undervolt_flag)
		else $error("undervolt flag not set while fault present");

	chk_reset_flag: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		i_hard_reset |=> err_q.reset_flag ##1 o_err_low_flags.reset_flag)
		else $error("reset flag not raised by hard reset");

	chk_low_field: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(field_tick && (i_field_sample < i_low_field_threshold)) |=> err_q.low_field_flag)
		else $error("low field flag missed");

	chk_warn_sticky: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!i_warn_clear |=> ((warn_q[11:1] & $past(warn_q[11:1])) == $past(warn_q[11:1])))
		else $error("warning dropped without clear");

	chk_iface_frame: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_pkt_done && (i_pkt_bit_count != PKT_BITS)) |=> (warn_q[11] && o_pkt_discard))
		else $error("bad frame not flagged and discarded");

	chk_crc_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_pkt_done && !i_serial_crc_check_enable && !i_pkt_bit15
			&& (i_pkt_bit_count == PKT_BITS)) |=> !o_pkt_discard)
		else $error("packet discarded with crc check off");

	chk_overrun: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(ext_busy_q && i_ext_start) |=> warn_q[2])
		else $error("extended overrun not flagged");

	chk_turns_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(warn_q[0] && !i_turns_reset) |=> warn_q[0])
		else $error("turns overflow cleared without turns reset");

	chk_warn_id: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_rd_en && word_hit(i_rd_addr, WARN_ADDR)) |=> (o_rd_valid && (o_rd_data[15:12] == WARN_ID)
			&& !o_rd_data[9]))
		else $error("warning word identifier or bit9 wrong");

	chk_summary: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(warn_q[4] && !i_warn_mask[4]) |=> o_summary_error_bit)
		else $error("summary bit not raised");

	chk_crc_flag: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_pkt_done && i_serial_crc_check_enable && !i_pkt_crc_ok && !i_pkt_bit15
			&& (i_pkt_bit_count == PKT_BITS)) |=> (warn_q[10] && o_pkt_discard))
		else $error("crc mismatch not flagged and discarded");

	chk_slew_warn: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_slew_limit_enable && i_slew_limit_needed) |=> warn_q[8])
		else $error("slew limit warning missed");

	chk_ext_exec: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_ext_cmd_done && i_ext_write && (!i_unlocked || i_eeprom_write_fail)) |=> warn_q[7])
		else $error("extended execute warning missed");

	chk_temp_clamp: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_temp_valid && (i_temp_raw > TEMP_MAX_CODE)) |=> (temp_word == TEMP_MAX_CODE[11:0]) ##1 warn_q[6])
		else $error("hot temperature not clamped or flagged");

	chk_temp_floor: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_temp_valid && (i_temp_raw < TEMP_MIN_CODE)) |=> (temp_word == TEMP_MIN_CODE[11:0]) ##1 warn_q[6])
		else $error("cold temperature not clamped or flagged");

	chk_ecc_warn: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_eeprom_loading && i_ecc_corrected) |=> warn_q[5])
		else $error("eeprom soft error warning missed");

	chk_sat_warn: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		i_sat_any |=> warn_q[4])
		else $error("saturation warning missed");

	chk_high_field: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(field_tick && (i_field_sample > i_high_field_threshold)) |=> warn_q[1])
		else $error("high field warning missed");

	chk_field_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!field_tick |=> $stable(field_q))
		else $error("field word moved between ticks");

	chk_err_sticky: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(!i_err_clear && err_q.reset_flag) |=> err_q.reset_flag)
		else $error("reset flag dropped without clear");
endmodule // swr_status_regs

/* File: logic/swr_pkg.sv */
package swr_pkg;

	// =====================================================================
	// register map (byte addresses of the high byte of each word)
	localparam logic [7:0] WARN_ADDR = 8'h26;
	localparam logic [7:0] TEMP_ADDR = 8'h28;
	localparam logic [7:0] FIELD_ADDR = 8'h2A;

	// hard-coded identifier nibbles in bits 15..12
	localparam logic [3:0] WARN_ID = 4'hB;
	localparam logic [3:0] TEMP_ID = 4'hF;
	localparam logic [3:0] FIELD_ID = 4'hE;

	// =====================================================================
	// error flag positions and values after reset
	localparam int ERR_RESET_BIT = 0;
	localparam int ERR_LOW_FIELD_BIT = 1;
	localparam int ERR_UNDERVOLT_BIT = 2;
	localparam logic [2:0] ERR_RESET_VAL = 3'h1;
	localparam logic [11:0] WARN_RESET_VAL = 12'h000;
	localparam logic [11:0] TEMP_RESET_VAL = 12'h000;
	localparam logic [11:0] FIELD_RESET_VAL = 12'h000;

	// =====================================================================
	// serial framing
	localparam logic [5:0] PKT_BITS = 6'h10;

	// =====================================================================
	// timing
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int FIELD_PERIOD_US = 128;
	localparam int FIELD_PERIOD_CYC = FIELD_PERIOD_US * (CLK_FREQ_HZ / 1_000_000);
	localparam logic [10:0] FIELD_CNT_LAST = 11'(FIELD_PERIOD_CYC - 1);

	// =====================================================================
	// temperature scaling: code = (degC - 25) * 8
	localparam int TEMP_REF_C = 25;
	localparam int TEMP_STEPS_PER_C = 8;
	localparam int TEMP_LOW_C = -60;
	localparam int TEMP_HIGH_C = 180;
	localparam logic signed [13:0] TEMP_MIN_CODE = 14'((TEMP_LOW_C - TEMP_REF_C) * TEMP_STEPS_PER_C);
	localparam logic signed [13:0] TEMP_MAX_CODE = 14'((TEMP_HIGH_C - TEMP_REF_C) * TEMP_STEPS_PER_C);

	// =====================================================================
	// angle change limit between awake states
	localparam int TURNS_WARN_DEG = 135;
	localparam int ANGLE_FULL_CODES = 4096;
	localparam logic [11:0] TURNS_WARN_CODE = 12'(TURNS_WARN_DEG * ANGLE_FULL_CODES / 360);

	// =====================================================================
	// carriers
	typedef struct packed {
		logic [3:0] reg_id;
		logic interface_fault_warning;
		logic crc_warning;
		logic zero_bit;
		logic slew_limit_warning;
		logic extended_exec_warning;
		logic temp_range_warning;
		logic eeprom_soft_warning;
		logic saturation_warning;
		logic turns_rate_warning;
		logic extended_overrun_warning;
		logic high_field_warning;
		logic turns_overflow_flag;
	} swr_warn_type;

	typedef struct packed {
		logic regulator_undervolt_flag;
		logic low_field_flag;
		logic reset_flag;
	} swr_err_type;

endpackage

/* File: logic/swr_sync.sv */
`timescale 1ns/1ps

// =====================================================================
// two-stage level synchroniser for detector pins
module swr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	import swr_pkg::*;

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule // swr_sync

/* File: logic/swr_temp_sat.sv */
`timescale 1ns/1ps

// =====================================================================
// temperature clamp and out-of-range detect
module swr_temp_sat (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_valid,
	input wire logic signed [13:0] i_raw,
	output logic [11:0] o_temp,
	output logic o_out_of_range
);
	import swr_pkg::*;

	// clamp each new sample; range pulse lasts one cycle
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_temp <= TEMP_RESET_VAL;
			o_out_of_range <= 1'b0;
		end else begin
			o_out_of_range <= 1'b0;
			if (i_valid) begin
				if (i_raw < TEMP_MIN_CODE) begin
					o_temp <= TEMP_MIN_CODE[11:0];
					o_out_of_range <= 1'b1;
				end else if (i_raw > TEMP_MAX_CODE) begin
					o_temp <= TEMP_MAX_CODE[11:0];
					o_out_of_range <= 1'b1;
				end else begin
					o_temp <= i_raw[11:0];
				end
			end
		end
	end
endmodule // swr_temp_sat

/* File: verification/swr_host_model.sv */
`timescale 1ns/1ps

// =====================================================================
// host side: turns bench commands into read and clear strobes
module swr_host_model (
	input wire logic i_mclk,
	input wire logic i_go,
	input wire logic [1:0] i_op,
	input wire logic [7:0] i_addr,
	output logic o_rd_en,
	output logic [7:0] o_rd_addr,
	output logic o_err_clear,
	output logic o_warn_clear,
	output logic o_turns_reset
);
	logic go_s;
	logic [1:0] op_s;
	logic [7:0] addr_s;

	initial begin
		o_rd_en = 1'b0;
		o_rd_addr = 8'hFF;
		o_err_clear = 1'b0;
		o_warn_clear = 1'b0;
		o_turns_reset = 1'b0;
	end

	// capture at the edge, launch just after it, so strobes are one cycle wide
	always @(posedge i_mclk) begin
		go_s = i_go;
		op_s = i_op;
		addr_s = i_addr;
		#1;
		o_rd_en <= go_s && (op_s == 2'h0);
		o_err_clear <= go_s && (op_s == 2'h1);
		o_warn_clear <= go_s && (op_s == 2'h2);
		o_turns_reset <= go_s && (op_s == 2'h3);
		// idle address flips every cycle so a stale value never looks valid
		o_rd_addr <= (go_s && op_s == 2'h0) ? addr_s : ~o_rd_addr;
	end
endmodule // swr_host_model

/* File: verification/swr_status_regs_tb.sv */
`timescale 1ns/1ps

// =====================================================================
// bench for the diagnostic status words
module swr_status_regs_tb;
	import swr_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic go = 1'b0;
	logic [1:0] op = 2'h0;
	logic [7:0] addr = 8'h00;
	logic [19:0] ev = '0;
	logic uv = 1'b0;
	logic lp = 1'b0;
	logic tv = 1'b0;
	logic [11:0] fld = 12'h0C7;
	logic [11:0] ang = '0;
	logic signed [13:0] traw = '0;
	logic [2:0] emsk = '0;
	logic [11:0] wmsk = '0;
	logic rd_en, err_clr, warn_clr, turns_rst, rd_valid, summary, discard;
	logic [7:0] rd_addr;
	logic [15:0] rd_data;
	swr_err_type err;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h01DCE913;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int r;
	int c;
	int tlim[5] = '{-681, -680, 1240, 1241, -8000};
	// {expected warning bits, event vector}; bit 19 shortens the packet
	logic [31:0] tab[19] = '{
		32'h80080001, 32'h80000003, 32'h80000004, 32'h40000009, 32'h00000001,
		32'h00000019, 32'h10000060, 32'h00000040, 32'h08000300, 32'h08000F00,
		32'h00000700, 32'h02003000, 32'h00002000, 32'h00400080, 32'h00000100,
		32'h00000080, 32'h00000100, 32'h01004000, 32'h00108000};

	swr_host_model swr_host_model_inst (.i_mclk(i_mclk), .i_go(go), .i_op(op),
		.i_addr(addr), .o_rd_en(rd_en), .o_rd_addr(rd_addr), .o_err_clear(err_clr),
		.o_warn_clear(warn_clr), .o_turns_reset(turns_rst));

	swr_status_regs swr_status_regs_inst (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_err_clear(err_clr),
		.i_warn_clear(warn_clr), .i_turns_reset(turns_rst), .i_hard_reset(ev[18]),
		.i_regulator_undervolt(uv), .i_field_sample(fld),
		.i_low_field_threshold(12'h0C8), .i_high_field_threshold(12'h4B0),
		.i_temp_valid(tv), .i_temp_raw(traw), .i_pkt_done(ev[0]),
		.i_pkt_bit_count(ev[19] ? 6'h0F : PKT_BITS), .i_pkt_bit15(ev[1]),
		.i_manchester_err(ev[2]), .i_serial_crc_check_enable(ev[3]),
		.i_pkt_crc_ok(ev[4]), .i_slew_limit_enable(ev[5]), .i_slew_limit_needed(ev[6]),
		.i_ext_start(ev[7]), .i_ext_cmd_done(ev[8]), .i_ext_write(ev[9]),
		.i_unlocked(ev[10]), .i_eeprom_write_fail(ev[11]), .i_eeprom_loading(ev[12]),
		.i_ecc_corrected(ev[13]), .i_sat_any(ev[14]), .i_low_power_mode(lp),
		.i_awake_strobe(ev[17]), .i_zcd_angle(ang), .i_turns_overflow(ev[15]),
		.i_err_mask(emsk), .i_warn_mask(wmsk), .o_rd_data(rd_data),
		.o_rd_valid(rd_valid), .o_err_low_flags(err), .o_summary_error_bit(summary),
		.o_pkt_discard(discard));

	initial begin
		forever #50 i_mclk = ~i_mclk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	// one host command: op 0 read, 1 error clear, 2 warning clear, 3 turns reset
	task automatic host(input logic [1:0] o, input logic [7:0] a);
		go = 1'b1;
		op = o;
		addr = a;
		step(1);
		go = 1'b0;
		step(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host(2'h0, a);
		step(1);
	endtask

	task automatic pulse(input logic [19:0] v, input int n);
		ev = v;
		step(n);
		ev = '0;
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// read data stands one cycle, so the falling edge sees each answer once
	always @(negedge i_mclk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				bad_count++;
				$display("[FAIL] %0t unexpected read answer", $time);
			end else begin
				check(rd_data, exp_q.pop_front());
			end
		end
	end

	// hang guard: the whole sequence needs well under half of this
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			bad_count++;
			finish_test();
		end
	end

	initial begin
		step(9);
		check({13'h0, err}, 16'h0001);
		step(1);
		i_rstn = 1'b1;
		rd(WARN_ADDR, {WARN_ID, 12'h000});
		rd(8'h27, {WARN_ID, 12'h000});
		rd(TEMP_ADDR, {TEMP_ID, 12'h000});
		rd(FIELD_ADDR, {FIELD_ID, 12'h000});
		rd(8'h30, 16'h0000);
		$display("reset test done");
		// field word and limits follow the periodic sample
		step(1290);
		rd(FIELD_ADDR, {FIELD_ID, 12'h0C7});
		check({13'h0, err}, 16'h0003);
		fld = 12'h4B1;
		step(1280);
		rd(FIELD_ADDR, {FIELD_ID, 12'h4B1});
		rd(WARN_ADDR, {WARN_ID, 12'h002});
		fld = 12'h4B0;
		step(1280);
		host(2'h1, 8'h00);
		host(2'h2, 8'h00);
		rd(WARN_ADDR, {WARN_ID, 12'h000});
		check({13'h0, err}, 16'h0000);
		$display("field test done");
		// undervoltage keeps setting while present, summary honours the mask
		uv = 1'b1;
		step(5);
		check({13'h0, err}, 16'h0004);
		host(2'h1, 8'h00);
		step(3);
		check({13'h0, err}, 16'h0004);
		uv = 1'b0;
		step(5);
		check({13'h0, err}, 16'h0004);
		check({15'h0, summary}, 16'h0001);
		emsk = 3'h4;
		step(3);
		check({15'h0, summary}, 16'h0000);
		emsk = 3'h0;
		host(2'h1, 8'h00);
		step(2);
		check({13'h0, err}, 16'h0000);
		pulse(20'h40000, 1);
		step(3);
		check({13'h0, err}, 16'h0001);
		host(2'h1, 8'h00);
		$display("error test done");
		// packet, slew, extended, eeprom, saturation and turns overflow causes, their discard, persistence across reads and clearing
		for (int k = 0; k < 19; k++) begin
			pulse(tab[k][19:0], (k == 13) ? 2 : 1);
			check({15'h0, discard}, 16'(k == 0 || k == 1 || k == 3));
			rd(WARN_ADDR, {WARN_ID, tab[k][31:20]});
			rd(WARN_ADDR, {WARN_ID, tab[k][31:20]});
			host(2'h2, 8'h00);
			rd(WARN_ADDR, {WARN_ID, tab[k][31:20] & 12'h001});
		end
		host(2'h3, 8'h00);
		rd(WARN_ADDR, {WARN_ID, 12'h000});
		$display("warning test done");
		// angle jump of exactly 135 degrees passes, one code more is flagged
		lp = 1'b1;
		seed = lfsr_next(seed);
		ang = seed[11:0];
		pulse(20'h20000, 1);
		ang = ang + 12'h600;
		pulse(20'h20000, 1);
		rd(WARN_ADDR, {WARN_ID, 12'h000});
		ang = ang + 12'h601;
		pulse(20'h20000, 1);
		rd(WARN_ADDR, {WARN_ID, 12'h008});
		check({15'h0, summary}, 16'h0001);
		wmsk = 12'h008;
		step(2);
		check({15'h0, summary}, 16'h0000);
		wmsk = 12'h000;
		lp = 1'b0;
		host(2'h2, 8'h00);
		$display("turns test done");
		// temperature limits, clamping and random in-range codes
		for (int k = 0; k < 8; k++) begin
			seed = lfsr_next(seed);
			r = (k < 5) ? tlim[k] : int'(seed % 1921) - 680;
			c = (r < -680) ? -680 : ((r > 1240) ? 1240 : r);
			traw = 14'(r);
			tv = 1'b1;
			step(1);
			tv = 1'b0;
			rd(TEMP_ADDR, {TEMP_ID, 12'(c)});
			rd(WARN_ADDR, {WARN_ID, (r != c) ? 12'h040 : 12'h000});
			host(2'h2, 8'h00);
		end
		step(3);
		check({15'h0, summary}, 16'h0000);
		$display("temperature test done");
		if (exp_q.size() != 0) begin
			bad_count++;
			$display("[FAIL] %0t reads left unanswered", $time);
		end
		finish_test();
	end
endmodule // swr_status_regs_tb
